// [saic_pkg.sv]
`default_nettype none
package saic_pkg;
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int HALT_TIMEOUT_NS = 100_000;
  localparam int HALT_CYC = HALT_TIMEOUT_NS / (1_000_000_000 / SYS_CLK_HZ);
  localparam int MAX_2CH_FRAME_HZ = 92_000;
  localparam int MIN_2CH_CYC = SYS_CLK_HZ / MAX_2CH_FRAME_HZ;
  // frame period windows in system cycles, split between rate families
  localparam int RATE_MAX_CYC = 700;
  localparam int RATE32_MIN_CYC = 540;
  localparam int RATE48_MIN_CYC = 300;
  localparam int RATE96_MIN_CYC = 150;
  localparam int GOOD_FRAMES = 4;
  localparam int TDM_SLOT_BITS = 32;
  localparam logic [7:0] FMT_CFG_ADDR = 8'h33;
  localparam logic [7:0] STATUS_ADDR = 8'h71;
  localparam logic [7:0] FMT_CFG_RESET = 8'h02;
  localparam int FMT_LSB = 4;
  localparam int WLEN_LSB = 0;
  localparam int ST_CLK_ERR = 0;
  localparam int ST_HALT = 1;
  localparam int ST_RATIO = 2;
  localparam int ST_RATE_LSB = 4;
  typedef enum logic [1:0] {
    FMT_I2S = 2'b00,
    FMT_LEFT_ALIGNED = 2'b01,
    FMT_RIGHT_ALIGNED = 2'b10,
    FMT_TDM = 2'b11
  } saic_fmt_t;
  typedef enum logic [1:0] {
    RATE_NONE = 2'b00,
    RATE_32K = 2'b01,
    RATE_48K = 2'b10,
    RATE_96K = 2'b11
  } saic_rate_t;
  typedef enum logic {
    ST_SLEEP = 1'b0,
    ST_PLAY = 1'b1
  } saic_state_t;
endpackage : saic_pkg
`default_nettype wire

// [saic_pll_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface saic_pll_if;
  logic bit_edge;
  logic tick;
  logic locked;
  modport core (output bit_edge, input tick, input locked);
  modport pll (input bit_edge, output tick, output locked);
endinterface : saic_pll_if
`default_nettype wire

// [saic_pll.sv]
`timescale 1ns/10ps
`default_nettype none
// digital clock multiplier: tracks the bit-clock period and emits two
// processing ticks per bit, flagging lock when the period is steady
module saic_pll #(
  parameter int CNT_W = 8
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst,     // synchronous reset
  saic_pll_if.pll pif         // bit edges in, ticks and lock out
);
  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] diff;

  assign diff = (per_cnt > period) ? per_cnt - period : period - per_cnt;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      per_cnt <= '0;
      period <= '0;
      pif.locked <= 1'b0;
    end else if (pif.bit_edge) begin
      per_cnt <= '0;
      period <= per_cnt;
      pif.locked <= (per_cnt > {{(CNT_W-2){1'b0}}, 2'b11}) &&
                    (diff <= {{(CNT_W-1){1'b0}}, 1'b1});
    end else if (per_cnt == {CNT_W{1'b1}}) begin
      pif.locked <= 1'b0;
    end else begin
      per_cnt <= per_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pif.tick <= 1'b0;
    end else begin
      pif.tick <= pif.locked && (pif.bit_edge ||
                  (per_cnt == (period >> 1)));
    end
  end
endmodule : saic_pll
`default_nettype wire

// [saic_top.sv]
// Summary of operation
// - processing ticks are multiplied from the bit clock; no master clock.
// - frame period classifies 32k, 44.1-48k, 88.2-96k families automatically.
// - on a clock halt, processor sleeps and amplifier outputs go high-Z.
// - playback resumes alone once clocks return; configuration is kept.
// - serial data is shifted in on each bit-clock rising edge only.
// - word clock is channel select in two-channel, frame sync in TDM.
// - two-channel formats take 16-32 bit words, 32 or 64 bits per frame.
// - TDM takes 128, 128/256/512, 128/256 bits per frame by rate family.
// - clock error shows in the status register at 0x71.
// - MSB-first two's complement up to 32 bits; reset is I2S, 24 bits.
// - TDM frame starts at the rising edge of frame sync.
`timescale 1ns/10ps
`default_nettype none
module saic_top import saic_pkg::*; (
  input wire logic i_sys_clk,                // 20 MHz system clock
  input wire logic i_rst,                    // synchronous reset, high
  input wire logic i_bit_clk,                // serial bit clock pin
  input wire logic i_word_select_frame_sync, // word select or frame sync
  input wire logic i_serial_audio_input,     // serial data pin
  input wire logic i_reg_wr,                 // register write strobe
  input wire logic [7:0] i_reg_addr,         // register address
  input wire logic [7:0] i_reg_wdata,        // register write data
  output logic [7:0] o_reg_rdata,            // register read data
  output logic [31:0] o_sample_left,         // left sample, MSB aligned
  output logic [31:0] o_sample_right,        // right sample, MSB aligned
  output logic o_sample_valid,               // sample pair pulse
  output logic [1:0] o_sample_rate,          // detected rate family
  output logic o_proc_tick,                  // processing clock tick
  output logic o_dsp_sleep,                  // processor sleep
  output logic o_amp_hiz,                    // amplifier outputs high-Z
  output logic o_clock_error                 // clock error level
);
  saic_pll_if pif ();
  saic_pll #(.CNT_W(8)) u_pll (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .pif(pif)
  );

  logic [2:0] bck_q;
  logic [1:0] ws_q;
  logic [1:0] sd_q;
  logic [7:0] fmt_cfg;
  logic ws_prev;
  logic [31:0] shreg;
  logic [9:0] cnt;
  logic [10:0] fbits;
  logic [11:0] frame_cyc;
  logic [11:0] bit_idle;
  logic [11:0] frame_idle;
  logic [2:0] good_run;
  logic ratio_err;
  saic_rate_t rate;
  saic_state_t state;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      bck_q <= '0;
      ws_q <= '0;
      sd_q <= '0;
    end else begin
      bck_q <= {bck_q[1:0], i_bit_clk};
      ws_q <= {ws_q[0], i_word_select_frame_sync};
      sd_q <= {sd_q[0], i_serial_audio_input};
    end
  end

  logic bit_rise, bit_any, ws_s, sd_s, tdm, boundary, frame_edge, halted;
  saic_fmt_t fmt;
  logic [5:0] wlen;
  assign bit_rise = bck_q[1] & ~bck_q[2];
  assign bit_any = bck_q[1] ^ bck_q[2];
  assign ws_s = ws_q[1];
  assign sd_s = sd_q[1];
  assign fmt = saic_fmt_t'(fmt_cfg[FMT_LSB +: 2]);
  assign tdm = (fmt == FMT_TDM);
  assign frame_edge = bit_rise & ws_s & ~ws_prev;
  assign boundary = tdm ? frame_edge : bit_rise & (ws_s ^ ws_prev);
  assign halted = (state == ST_SLEEP);
  assign pif.bit_edge = bit_rise;

  always_comb begin
    unique case (fmt_cfg[WLEN_LSB +: 2])
      2'b00: wlen = 6'd16;
      2'b01: wlen = 6'd20;
      2'b10: wlen = 6'd24;
      2'b11: wlen = 6'd32;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fmt_cfg <= FMT_CFG_RESET;
    end else if (i_reg_wr && i_reg_addr == FMT_CFG_ADDR) begin
      fmt_cfg <= i_reg_wdata;
    end
  end

  // serial shift path, clocked only by bit-clock rising edges
  logic [31:0] next_shreg;
  logic [9:0] next_cnt;
  assign next_shreg = {shreg[30:0], sd_s};
  assign next_cnt = boundary ? 10'd1 :
                    (cnt == 10'h3FF) ? cnt : cnt + 10'd1;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      shreg <= '0;
      cnt <= '0;
      ws_prev <= 1'b0;
    end else if (bit_rise) begin
      shreg <= next_shreg;
      cnt <= next_cnt;
      ws_prev <= ws_s;
    end
  end

  logic lat_en, lat_left;
  logic [31:0] lat_data;
  logic [5:0] lsh;
  logic [9:0] w_end;
  assign lsh = 6'd32 - wlen;
  assign w_end = {4'd0, wlen} + ((fmt == FMT_I2S) ? 10'd1 : 10'd0);

  always_comb begin
    lat_en = 1'b0;
    lat_left = 1'b0;
    lat_data = next_shreg << lsh;
    if (bit_rise) begin
      unique case (fmt)
        FMT_I2S: begin
          // a word that fills its slot ends on the next select change
          lat_en = boundary ? (cnt == {4'd0, wlen}) :
                   (next_cnt == w_end);
          lat_left = boundary ? ws_s : ~ws_s;
        end
        FMT_LEFT_ALIGNED: begin
          lat_en = (next_cnt == w_end);
          lat_left = ws_s;
        end
        FMT_RIGHT_ALIGNED: begin
          lat_en = boundary;
          lat_left = ~ws_s;
          lat_data = shreg << lsh;
        end
        FMT_TDM: begin
          lat_en = (next_cnt == {4'd0, wlen}) ||
                   (next_cnt == 10'(TDM_SLOT_BITS) + {4'd0, wlen});
          lat_left = (next_cnt == {4'd0, wlen});
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_sample_left <= '0;
      o_sample_right <= '0;
      o_sample_valid <= 1'b0;
    end else begin
      o_sample_valid <= lat_en & ~lat_left & ~halted;
      if (lat_en && lat_left) begin
        o_sample_left <= lat_data;
      end
      if (lat_en && !lat_left) begin
        o_sample_right <= lat_data;
      end
    end
  end

  // frame measurement in bit clocks and in system cycles
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fbits <= '0;
    end else if (bit_rise) begin
      fbits <= frame_edge ? 11'd1 :
               (fbits == 11'h7FF) ? fbits : fbits + 11'd1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      frame_cyc <= '0;
    end else begin
      frame_cyc <= frame_edge ? 12'd1 :
                   (frame_cyc == 12'hFFF) ? frame_cyc : frame_cyc + 12'd1;
    end
  end

  saic_rate_t meas_rate;
  logic meas_ok;
  always_comb begin
    if (frame_cyc > 12'(RATE_MAX_CYC)) begin
      meas_rate = RATE_NONE;
    end else if (frame_cyc >= 12'(RATE32_MIN_CYC)) begin
      meas_rate = RATE_32K;
    end else if (frame_cyc >= 12'(RATE48_MIN_CYC)) begin
      meas_rate = RATE_48K;
    end else if (frame_cyc >= 12'(RATE96_MIN_CYC)) begin
      meas_rate = RATE_96K;
    end else begin
      meas_rate = RATE_NONE;
    end
    if (tdm) begin
      meas_ok = (fbits == 11'd128 && meas_rate != RATE_NONE) ||
                (fbits == 11'd256 && meas_rate >= RATE_48K) ||
                (fbits == 11'd512 && meas_rate == RATE_48K);
    end else begin
      meas_ok = (fbits == 11'd32 || fbits == 11'd64) &&
                (meas_rate != RATE_NONE) &&
                (frame_cyc >= 12'(MIN_2CH_CYC));
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rate <= RATE_NONE;
      ratio_err <= 1'b0;
    end else if (frame_edge) begin
      rate <= meas_rate;
      ratio_err <= ~meas_ok;
    end
  end

  // halt watchdog on the free-running system clock
  logic halt_now;
  assign halt_now = (bit_idle == 12'(HALT_CYC)) ||
                    (frame_idle == 12'(HALT_CYC));
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      bit_idle <= '0;
      frame_idle <= '0;
    end else begin
      bit_idle <= bit_any ? 12'd0 :
                  halt_now ? bit_idle : bit_idle + 12'd1;
      frame_idle <= (ws_q[1] ^ ws_prev) ? 12'd0 :
                    halt_now ? frame_idle : frame_idle + 12'd1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || halt_now) begin
      good_run <= '0;
    end else if (frame_edge) begin
      good_run <= !meas_ok ? 3'd0 :
                  (good_run == 3'(GOOD_FRAMES)) ? good_run : good_run + 3'd1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= ST_SLEEP;
    end else begin
      unique case (state)
        ST_PLAY: if (halt_now) state <= ST_SLEEP;
        ST_SLEEP: if (!halt_now && pif.locked &&
                      good_run == 3'(GOOD_FRAMES)) state <= ST_PLAY;
      endcase
    end
  end

  logic [7:0] status;
  assign status = {2'b00, rate, 1'b0, ratio_err, halted,
                   halted | ratio_err};
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_reg_rdata <= '0;
    end else begin
      unique case (i_reg_addr)
        FMT_CFG_ADDR: o_reg_rdata <= fmt_cfg;
        STATUS_ADDR: o_reg_rdata <= status;
        default: o_reg_rdata <= '0;
      endcase
    end
  end

  assign o_sample_rate = rate;
  assign o_proc_tick = pif.tick & ~halted;
  assign o_dsp_sleep = halted;
  assign o_amp_hiz = halted;
  assign o_clock_error = halted | ratio_err;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_idle_out;
    halt_now;
  endsequence
  sequence s_asleep;
    o_amp_hiz && o_dsp_sleep;
  endsequence
  property p_halt_hiz;
    s_idle_out |=> s_asleep;
  endproperty
  a_halt_hiz: assert property (p_halt_hiz)
    else $error("halt did not force sleep and high-Z");
  property p_halt_cause;
    $rose(halted) |-> $past(bit_idle) == 12'(HALT_CYC) ||
                      $past(frame_idle) == 12'(HALT_CYC);
  endproperty
  a_halt_cause: assert property (p_halt_cause)
    else $error("halt entered without timeout");
  property p_recover;
    $fell(halted) |-> $past(good_run) == 3'(GOOD_FRAMES) &&
                      $past(pif.locked);
  endproperty
  a_recover: assert property (p_recover)
    else $error("left sleep without stable clocks");
  property p_status;
    (i_reg_addr == STATUS_ADDR && o_clock_error) |=> o_reg_rdata[ST_CLK_ERR];
  endproperty
  a_status: assert property (p_status)
    else $error("clock error missing from status");
  property p_shift;
    bit_rise |=> shreg[0] == $past(sd_s) && shreg[31:1] == $past(shreg[30:0]);
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit not shifted in");
  property p_frame_start;
    (tdm && frame_edge) |=> cnt == 10'd1;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("tdm frame did not restart on sync rise");
  property p_wlen16;
    (o_sample_valid && fmt_cfg[WLEN_LSB +: 2] == 2'b00 && $stable(fmt_cfg))
      |-> o_sample_right[15:0] == 16'h0000;
  endproperty
  a_wlen16: assert property (p_wlen16)
    else $error("16-bit sample not MSB aligned");
  property p_ratio_2ch;
    (frame_edge && !tdm && fbits == 11'd48) |=> ratio_err ##1 o_clock_error;
  endproperty
  a_ratio_2ch: assert property (p_ratio_2ch)
    else $error("bad two-channel ratio not flagged");
  property p_ratio_tdm;
    (frame_edge && tdm && fbits == 11'd512 && meas_rate == RATE_96K)
      |=> ratio_err;
  endproperty
  a_ratio_tdm: assert property (p_ratio_tdm)
    else $error("bad tdm ratio not flagged");
  property p_tdm_rate;
    (frame_edge && tdm && meas_rate == RATE_NONE) |=> ratio_err;
  endproperty
  a_tdm_rate: assert property (p_tdm_rate)
    else $error("tdm frame without a rate not flagged");
  property p_rate48;
    (frame_edge && frame_cyc >= 12'(RATE48_MIN_CYC) &&
     frame_cyc < 12'(RATE32_MIN_CYC)) |=> rate == RATE_48K;
  endproperty
  a_rate48: assert property (p_rate48)
    else $error("48k family not detected");
  property p_tick;
    o_proc_tick |-> pif.locked && !o_dsp_sleep;
  endproperty
  a_tick: assert property (p_tick)
    else $error("processing tick without lock");
endmodule : saic_top
`default_nettype wire

// [saic_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// host side of the serial audio link: bit clock, word select and data,
// MSB first; i2s left on select low, aligned formats left on select high,
// tdm four slots of i_slot_bits bits, the first data bit under a one-bit sync pulse
module saic_host_model import saic_pkg::*; (
  input wire logic i_run,             // stream frames while high
  input wire logic [1:0] i_fmt,       // link format, config encoding
  input wire logic [5:0] i_slot_bits, // bit clocks per channel slot
  input wire logic [31:0] i_left,     // left word for the next frame
  input wire logic [31:0] i_right,    // right word for the next frame
  output logic o_bit_clk,             // serial bit clock
  output logic o_ws,                  // word select
  output logic o_sd,                  // serial data
  output logic o_frame_mark           // toggles at each frame start
);
  logic [31:0] cur_l;
  logic [31:0] cur_r;
  logic [31:0] word;
  int n;
  int slots;
  logic tail;
  initial begin
    tail = 1'b0;
    o_bit_clk = 1'b0;
    o_ws = 1'b1;
    o_sd = 1'b0;
    o_frame_mark = 1'b0;
    #13;
    forever begin
      if (!i_run) begin
        // clocks stand still, released data line keeps changing
        o_bit_clk = 1'b0;
        #400 o_sd = ~o_sd;
      end else begin
        cur_l = i_left;
        cur_r = i_right;
        n = int'(i_slot_bits);
        slots = (i_fmt == FMT_TDM) ? 4 : 2;
        o_frame_mark = ~o_frame_mark;
        for (int h = 0; h < slots; h++) begin
          word = (h == 0) ? cur_l : (h == 1) ? cur_r : 32'h0;
          for (int i = 0; i < n; i++) begin
            #200 o_bit_clk = 1'b0;
            if (i_fmt == FMT_TDM) begin
              // sync high for one bit clock, first data bit under it
              o_ws = (h == 0 && i == 0);
              o_sd = word[31 - i];
            end else if (i_fmt == FMT_I2S) begin
              if (i == 0) o_ws = h[0];
              // one bit after the select; a full word spills one bit over
              o_sd = (i > 0) ? word[32 - i] : tail;
            end else begin
              if (i == 0) o_ws = ~h[0];
              o_sd = word[31 - i];
            end
            #200 o_bit_clk = 1'b1;
          end
          tail = word[32 - n];
        end
      end
    end
  end
endmodule : saic_host_model
`default_nettype wire

// [test_serial_audio_input_clocking.sv]
`timescale 1ns/10ps
`default_nettype none
module test_serial_audio_input_clocking;
  import saic_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bclk, ws, sd, frame_mark;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] rdata, rd;
  logic [31:0] s_left, s_right, pair_l = 32'h0, pair_r = 32'h0;
  logic valid, tick, sleep, hiz, cerr, run = 1'b0, chk_on = 1'b0;
  logic [1:0] rate;
  logic [5:0] slot_bits = 6'h20;
  logic [63:0] e;
  logic [63:0] expq[$];
  int err_total = 0;
  int compares = 0;
  int tick_cnt = 0;
  int tick_ref = 0;
  logic [1:0] fmt_sel = 2'h0;

  saic_host_model i_host (.i_run(run), .i_fmt(fmt_sel),
    .i_slot_bits(slot_bits),
    .i_left(pair_l), .i_right(pair_r), .o_bit_clk(bclk), .o_ws(ws),
    .o_sd(sd), .o_frame_mark(frame_mark));

  saic_top i_dut (.i_sys_clk(clk), .i_rst(rst), .i_bit_clk(bclk),
    .i_word_select_frame_sync(ws), .i_serial_audio_input(sd),
    .i_reg_wr(reg_wr), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(rdata), .o_sample_left(s_left), .o_sample_right(s_right),
    .o_sample_valid(valid), .o_sample_rate(rate), .o_proc_tick(tick),
    .o_dsp_sleep(sleep), .o_amp_hiz(hiz), .o_clock_error(cerr));

  initial begin
    forever #25 clk = ~clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task end_sim;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : reg_write

  task reg_read(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    @(posedge clk);
    @(posedge clk);
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask : reg_read

  task wait_play;
    int k;
    k = 0;
    while (sleep !== 1'b0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
  endtask : wait_play

  task halt_link;
    run <= 1'b0;
    // the host ends its frame before the clocks stand still
    repeat (HALT_CYC + 700) @(posedge clk);
  endtask : halt_link

  // one expected pair per frame, compared when the pair comes out
  task frames(input int n, input logic [31:0] mask);
    repeat (n) begin
      @(frame_mark);
      @(posedge clk);
      expq.push_back({pair_l & mask, pair_r & mask});
      chk_on <= 1'b1;
      pair_l <= $urandom();
      pair_r <= $urandom();
    end
    @(frame_mark);
    @(posedge clk);
    chk_on <= 1'b0;
    check(32'(expq.size()), 32'h0);
  endtask : frames

  always @(posedge clk) begin
    if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
    if (valid === 1'b1 && chk_on) begin
      if (expq.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        e = expq.pop_front();
        check(s_left, e[63:32]);
        check(s_right, e[31:0]);
        check(32'(hiz), 32'h0);
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("ERROR t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim();
  end

  initial begin
    void'($urandom(32'h512B));
    pair_l = $urandom();
    pair_r = $urandom();
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reg_read(FMT_CFG_ADDR, rd);
    check(32'(rd), 32'(FMT_CFG_RESET));
    reg_read(8'h40, rd);
    check(32'(rd), 32'h0);
    reg_write(STATUS_ADDR, 8'hFF);
    reg_read(STATUS_ADDR, rd);
    check(32'(rd & 8'h03), 32'h3);
    // I2S, 64 bit clocks per frame, 24-bit words
    run <= 1'b1;
    wait_play();
    check(32'(sleep), 32'h0);
    check(32'(rate), 32'(RATE_48K));
    frames(6, 32'hFFFFFF00);
    tick_ref = tick_cnt;
    repeat (400) @(posedge clk);
    check(32'(tick_cnt - tick_ref >= 99 && tick_cnt - tick_ref <= 101),
          32'h1);
    reg_write(FMT_CFG_ADDR, 8'h01);
    halt_link();
    check({29'h0, sleep, hiz, cerr}, 32'h7);
    reg_read(STATUS_ADDR, rd);
    check(32'(rd & 8'h03), 32'h3);
    run <= 1'b1;
    wait_play();
    check({30'h0, hiz, cerr}, 32'h0);
    reg_read(FMT_CFG_ADDR, rd);
    check(32'(rd), 32'h01);
    frames(4, 32'hFFFFF000);
    // 48 bit clocks per frame is not a supported ratio
    halt_link();
    slot_bits <= 6'h18;
    run <= 1'b1;
    repeat (8) @(frame_mark);
    @(posedge clk);
    check({30'h0, sleep, cerr}, 32'h3);
    reg_read(STATUS_ADDR, rd);
    check(32'(rd & 8'h05), 32'h5);
    // 32 bit clocks per frame, 16-bit words: upper rate family
    halt_link();
    reg_write(FMT_CFG_ADDR, 8'h00);
    slot_bits <= 6'h10;
    run <= 1'b1;
    wait_play();
    check({29'h0, rate, cerr}, {29'h0, RATE_96K, 1'b0});
    reg_read(STATUS_ADDR, rd);
    check(32'(rd & 8'h37), 32'({2'b00, RATE_96K, 4'h0}));
    // left aligned, 64 bit clocks per frame, 24-bit words
    halt_link();
    reg_write(FMT_CFG_ADDR, 8'h12);
    fmt_sel <= FMT_LEFT_ALIGNED;
    slot_bits <= 6'h20;
    run <= 1'b1;
    wait_play();
    check(32'(sleep), 32'h0);
    frames(4, 32'hFFFFFF00);
    // tdm, 128 bit clocks per frame: no legal rate at this bit clock
    halt_link();
    reg_write(FMT_CFG_ADDR, 8'h32);
    fmt_sel <= FMT_TDM;
    pair_l <= $urandom();
    pair_r <= $urandom();
    run <= 1'b1;
    repeat (3) @(frame_mark);
    @(posedge clk);
    check(s_left, pair_l & 32'hFFFFFF00);
    check(s_right, pair_r & 32'hFFFFFF00);
    check({30'h0, sleep, cerr}, 32'h3);
    // reset in mid-stream: defaults return, device asleep
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(32'(sleep), 32'h1);
    reg_read(FMT_CFG_ADDR, rd);
    check(32'(rd), 32'(FMT_CFG_RESET));
    end_sim();
  end
endmodule : test_serial_audio_input_clocking
`default_nettype wire
